// >>> fgr_pkg.sv
/*
 * fgr_pkg: constants and carrier types for the fast gate and cpu reset block.
 * assumes a 50 MHz pclk and an apb register bus with 32-bit data.
 */
package fgr_pkg;
	// register byte addresses, plus the fast control word index
	localparam logic [11:0] FGR_FAST_CTRL_INDEX = 12'h092;
	localparam logic [11:0] FGR_FAST_CTRL_ADDR = 12'h248;
	localparam logic [11:0] FGR_PATH_CTRL_ADDR = 12'h000;
	localparam logic [11:0] FGR_PIN_CFG_ADDR = 12'h004;
	localparam logic [11:0] FGR_STATUS_ADDR = 12'h008;

	// fast control port layout
	localparam int FGR_RST_BIT = 0;
	localparam int FGR_GATE_BIT = 1;
	localparam int FGR_PATH_EN_BIT = 2;
	localparam logic [7:0] FGR_FAST_CTRL_FIXED = 8'h24;
	localparam logic [7:0] FGR_FAST_CTRL_RESET = 8'h24;

	// pin configuration register layout
	localparam int FGR_CFG_POL_BIT = 0;
	localparam int FGR_CFG_OD_BIT = 1;
	localparam logic [7:0] FGR_PATH_CTRL_RESET = 8'h00;
	localparam logic [7:0] FGR_PIN_CFG_RESET = 8'h00;

	// timing
	localparam int FGR_CLK_HZ = 50000000;
	localparam int FGR_DELAY_US = 14;
	localparam int FGR_PULSE_US = 6;
	localparam int FGR_DELAY_CYC = (FGR_DELAY_US * (FGR_CLK_HZ / 1000000));
	localparam int FGR_PULSE_CYC = (FGR_PULSE_US * (FGR_CLK_HZ / 1000000));
	localparam int FGR_BOOST_CYC = 4;
	localparam int FGR_CNT_W = 12;

	typedef enum logic [1:0] {
		FGR_IDLE = 2'b00,
		FGR_WAIT = 2'b01,
		FGR_PULSE = 2'b11,
		FGR_DONE = 2'b10
	} fgr_state_t;

	// one auxiliary pin as its level and its drive enable
	typedef struct packed {
		logic o;
		logic oe;
	} fgr_pin_t;
endpackage

// >>> fgr_fast_ctrl.sv
/*
 * fgr_fast_ctrl: fast address gate and cpu reset path with apb registers.
 * assumes a single 50 MHz clock; keyboard controller signals are synchronous.
 */
`timescale 1ns/1ps

// What this block does
// - address mask high when either kbc gate or fast gate line is high.
// - bit 1 of the fast control port sets the fast gate line level.
// - reset drives the fast gate line low.
// - writing bit 0 one waits 14us then pulses reset low 6us.
// - no new pulse until bit 0 returns to zero.
// - reset clears bit 0 and holds fast reset high.
// - path enable set ANDs fast reset with kbc reset onto combined output.
// - combined reset output polarity follows the pin polarity setting.
// - push mode drives auxiliary pin low for a zero bit.
// - push mode drives high briefly on a one, then releases to pull-up.
// - open-drain mode never drives high; one bit releases pin.
// - auxiliary pins ignore input or invert configuration.
// - fast control port responds only when path enable bit is set.
// - fast control reads return 24h fixed bits plus bits 1 and 0.
module fgr_fast_ctrl
	import fgr_pkg::*;
#(
	parameter int DELAY_CYC = FGR_DELAY_CYC,
	parameter int PULSE_CYC = FGR_PULSE_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// keyboard controller side
	input wire logic kbc_gate_out,
	input wire logic kbc_reset_n,
	input wire logic kbc_aux_port_a,
	input wire logic kbc_aux_port_b,
	// system side
	output logic cpu_addr_mask_n,
	output logic fast_gate_line,
	output logic fast_reset_pulse_n,
	output logic combined_reset_out,
	// auxiliary pins
	output logic kbc_aux_out_a_o,
	output logic kbc_aux_out_a_oe,
	output logic kbc_aux_out_b_o,
	output logic kbc_aux_out_b_oe
);

	logic [7:0] path_ctrl;
	logic [7:0] pin_cfg;
	logic rst_req;
	fgr_state_t state;
	logic [FGR_CNT_W-1:0] cnt;
	logic setup;
	logic wr_fire;
	logic fast_hit;
	logic known;
	logic hit_path;
	logic hit_cfg;
	logic hit_stat;
	logic merged_rst_n;
	logic [31:0] next_rdata;
	logic [1:0] aux_in;
	logic [1:0] aux_prev;
	logic [2:0] boost [2];
	fgr_pin_t pin [2];

	function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
		return a == ref_a;
	endfunction

	// single-cycle setup answer: pready is asserted in every access phase
	assign setup = psel && !penable;
	assign fast_hit = is_addr(paddr, FGR_FAST_CTRL_ADDR) && path_ctrl[FGR_PATH_EN_BIT];
	assign hit_path = is_addr(paddr, FGR_PATH_CTRL_ADDR);
	assign hit_cfg = is_addr(paddr, FGR_PIN_CFG_ADDR);
	assign hit_stat = is_addr(paddr, FGR_STATUS_ADDR);
	// a disabled fast port counts as unmapped, so it answers with an error and no effect
	assign known = fast_hit || hit_path || hit_cfg || hit_stat;
	assign wr_fire = psel && penable && pready && pwrite && known;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (fast_hit) begin
			next_rdata[7:0] = FGR_FAST_CTRL_FIXED | {6'h00, fast_gate_line, rst_req};
		end else if (hit_path) begin
			next_rdata[7:0] = path_ctrl;
		end else if (hit_cfg) begin
			next_rdata[7:0] = pin_cfg;
		end else if (hit_stat) begin
			next_rdata[1:0] = state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
			// unmapped or disabled port answers with an error
			pslverr <= !known;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			path_ctrl <= FGR_PATH_CTRL_RESET;
			pin_cfg <= FGR_PIN_CFG_RESET;
		end else if (wr_fire) begin
			if (hit_path) begin
				path_ctrl <= pwdata[7:0];
			end
			if (hit_cfg) begin
				pin_cfg <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_gate_line <= 1'b0;
			rst_req <= 1'b0;
		end else if (wr_fire && fast_hit) begin
			fast_gate_line <= pwdata[FGR_GATE_BIT];
			rst_req <= pwdata[FGR_RST_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= FGR_IDLE;
			cnt <= '0;
			fast_reset_pulse_n <= 1'b1;
		end else begin
			case (state)
				FGR_IDLE: begin
					if (wr_fire && fast_hit && pwdata[FGR_RST_BIT] && !rst_req) begin
						state <= FGR_WAIT;
						cnt <= '0;
					end
				end
				FGR_WAIT: begin
					if (cnt == FGR_CNT_W'(DELAY_CYC - 1)) begin
						state <= FGR_PULSE;
						cnt <= '0;
						fast_reset_pulse_n <= 1'b0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				FGR_PULSE: begin
					if (cnt == FGR_CNT_W'(PULSE_CYC - 1)) begin
						state <= FGR_DONE;
						fast_reset_pulse_n <= 1'b1;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				FGR_DONE: begin
					// rearm only once bit 0 is cleared
					if (!rst_req) begin
						state <= FGR_IDLE;
					end
				end
				default: begin
					state <= FGR_IDLE;
					fast_reset_pulse_n <= 1'b1;
				end
			endcase
		end
	end

	// and merge when enabled
	// a pulse already started still runs with the merge off, and only its effect on the pin is gated; a new one cannot start, as the fast port is then disabled
	always_comb begin
		merged_rst_n = kbc_reset_n;
		if (path_ctrl[FGR_PATH_EN_BIT]) begin
			merged_rst_n = kbc_reset_n & fast_reset_pulse_n;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_addr_mask_n <= 1'b0;
			combined_reset_out <= 1'b1;
		end else begin
			cpu_addr_mask_n <= kbc_gate_out | fast_gate_line;
			combined_reset_out <= merged_rst_n ^ pin_cfg[FGR_CFG_POL_BIT];
		end
	end

	assign aux_in = {kbc_aux_port_b, kbc_aux_port_a};

	// auxiliary pin drivers; the polarity bit is deliberately not applied here
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_aux
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					aux_prev[g] <= 1'b1;
					boost[g] <= 3'h0;
					pin[g] <= '{o: 1'b0, oe: 1'b0};
				end else begin
					aux_prev[g] <= aux_in[g];
					if (!aux_in[g]) begin
						boost[g] <= 3'h0;
						pin[g] <= '{o: 1'b0, oe: 1'b1};
					end else if (!aux_prev[g] && !pin_cfg[FGR_CFG_OD_BIT]) begin
						boost[g] <= 3'(FGR_BOOST_CYC - 1);
						pin[g] <= '{o: 1'b1, oe: 1'b1};
					end else if (boost[g] != 3'h0 && !pin_cfg[FGR_CFG_OD_BIT]) begin
						boost[g] <= boost[g] - 3'h1;
					end else begin
						boost[g] <= 3'h0;
						pin[g] <= '{o: 1'b0, oe: 1'b0};
					end
				end
			end
		end
	endgenerate

	assign kbc_aux_out_a_o = pin[0].o;
	assign kbc_aux_out_a_oe = pin[0].oe;
	assign kbc_aux_out_b_o = pin[1].o;
	assign kbc_aux_out_b_oe = pin[1].oe;
endmodule

// >>> fgr_board.sv
/* fgr_board: aux pin wires with their pull-ups.
   assumes the block's o/oe pairs. */
`timescale 1ns/1ps
module fgr_board (
	// pin drivers
	input wire logic a_o,
	input wire logic a_oe,
	input wire logic b_o,
	input wire logic b_oe,
	// pin levels
	output logic pin_a,
	output logic pin_b
);
	assign pin_a = a_oe ? a_o : 1'b1;
	assign pin_b = b_oe ? b_o : 1'b1;
endmodule

// >>> fgr_fast_ctrl_monitor.sv
/* fgr_fast_ctrl_monitor: port checks.
   assumes DELAY_CYC 5, PULSE_CYC 3. */
`timescale 1ns/1ps
module fgr_fast_ctrl_monitor (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	// kbc side
	input wire logic kbc_gate_out,
	input wire logic kbc_aux_port_a,
	input wire logic kbc_aux_port_b,
	// outputs
	input wire logic cpu_addr_mask_n,
	input wire logic fast_gate_line,
	input wire logic fast_reset_pulse_n,
	input wire logic kbc_aux_out_a_o,
	input wire logic kbc_aux_out_a_oe,
	input wire logic kbc_aux_out_b_o,
	input wire logic kbc_aux_out_b_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_mask; 1 |=> cpu_addr_mask_n == $past(kbc_gate_out | fast_gate_line); endproperty
	a_mask: assert property (p_mask) else $error("mask wrong");
	property p_gate; $changed(fast_gate_line) |-> $past(psel && penable && pwrite && pready); endproperty
	a_gate: assert property (p_gate) else $error("gate moved");
	property p_width; $fell(fast_reset_pulse_n) |-> (!fast_reset_pulse_n)[*3] ##1 fast_reset_pulse_n; endproperty
	a_width: assert property (p_width) else $error("pulse width");
	property p_gap; $rose(fast_reset_pulse_n) |=> fast_reset_pulse_n[*8]; endproperty
	a_gap: assert property (p_gap) else $error("pulse again");
	property p_boost; $rose(kbc_aux_out_a_oe && kbc_aux_out_a_o) |-> (kbc_aux_out_a_oe && kbc_aux_out_a_o)[*4] ##1 !kbc_aux_out_a_oe; endproperty
	a_boost: assert property (p_boost) else $error("boost length");
	property p_low_a; !kbc_aux_port_a |=> kbc_aux_out_a_oe && !kbc_aux_out_a_o; endproperty
	a_low_a: assert property (p_low_a) else $error("pin a not low");
	property p_low_b; !kbc_aux_port_b |=> kbc_aux_out_b_oe && !kbc_aux_out_b_o; endproperty
	a_low_b: assert property (p_low_b) else $error("pin b not low");
	property p_rdy; psel && penable |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no answer");
	c_pulse: cover property ($fell(fast_reset_pulse_n));
	c_err: cover property (pready && pslverr);
	c_boost: cover property ($rose(kbc_aux_out_a_oe && kbc_aux_out_a_o));
endmodule

// >>> fgr_fast_ctrl_test.sv
/* fgr_fast_ctrl_test: apb tests of the fast path.
   assumes the zero-wait apb slave. */
`timescale 1ns/1ps
module fgr_fast_ctrl_test;
	import fgr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic kbc_gate_out = 0, kbc_reset_n = 1, kbc_aux_port_a = 1, kbc_aux_port_b = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, cpu_addr_mask_n, fast_gate_line, fast_reset_pulse_n, combined_reset_out;
	logic kbc_aux_out_a_o, kbc_aux_out_a_oe, kbc_aux_out_b_o, kbc_aux_out_b_oe, pin_a, pin_b;
	int n_fail = 0, compares = 0, n;
	always #10 pclk = ~pclk;
	// short counts keep the run brief
	fgr_fast_ctrl #(.DELAY_CYC(5), .PULSE_CYC(3)) u_fgr_fast_ctrl (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .kbc_gate_out, .kbc_reset_n,
		.kbc_aux_port_a, .kbc_aux_port_b, .cpu_addr_mask_n, .fast_gate_line, .fast_reset_pulse_n,
		.combined_reset_out, .kbc_aux_out_a_o, .kbc_aux_out_a_oe, .kbc_aux_out_b_o, .kbc_aux_out_b_oe);
	fgr_board u_fgr_board (.a_o(kbc_aux_out_a_o), .a_oe(kbc_aux_out_a_oe), .b_o(kbc_aux_out_b_o),
		.b_oe(kbc_aux_out_b_oe), .pin_a, .pin_b);
	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			n_fail++;
		end
	endtask
	task acc(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// pready is looked at between edges, never in the time step that launches it
		@(negedge pclk);
		while (pready !== 1'b1) @(negedge pclk);
		@(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task conclude;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		cyc(5);
		presetn <= 1;
		cyc(1);
		chk(fast_gate_line, 0);
		chk({fast_reset_pulse_n, combined_reset_out}, 3);
		acc(FGR_FAST_CTRL_ADDR, 0, 0); chk(err, 1);
		acc(12'h00c, 0, 0); chk(err, 1);
		acc(FGR_PATH_CTRL_ADDR, 1, 4);
		acc(FGR_FAST_CTRL_ADDR, 0, 0); chk(r, 32'h24);
		$display("access test done");
		for (int i = 0; i < 4; i++) begin
			acc(FGR_FAST_CTRL_ADDR, 1, {i[1], 1'b0});
			kbc_gate_out <= i[0];
			cyc(2);
			chk(cpu_addr_mask_n, i != 0);
			chk(fast_gate_line, i[1]);
		end
		$display("gate test done");
		for (int k = 0; k < 2; k++) begin
			acc(FGR_FAST_CTRL_ADDR, 1, 1);
			n = 0;
			while (fast_reset_pulse_n && n < 50) begin
				cyc(1);
				n++;
			end
			chk(n >= 5, 1);
			cyc(1); chk(combined_reset_out, 0);
			acc(FGR_STATUS_ADDR, 0, 0); chk(r, 32'h2);
			acc(FGR_FAST_CTRL_ADDR, 1, 1);
			n = 0;
			repeat (20) begin
				cyc(1);
				n += !fast_reset_pulse_n;
			end
			chk(n, 0);
			acc(FGR_FAST_CTRL_ADDR, 1, 0);
		end
		$display("pulse test done");
		for (int i = 0; i < 4; i++) begin
			acc(FGR_PIN_CFG_ADDR, 1, i[0]);
			kbc_reset_n <= i[1];
			cyc(2);
			chk(combined_reset_out, i[1] ^ i[0]);
		end
		$display("polarity test done");
		for (int m = 0; m < 2; m++) begin
			acc(FGR_PIN_CFG_ADDR, 1, {m[0], 1'b1});
			kbc_aux_port_a <= 0;
			kbc_aux_port_b <= 0;
			cyc(2); chk({pin_a, pin_b}, 0);
			kbc_aux_port_a <= 1;
			kbc_aux_port_b <= 1;
			cyc(2); chk(kbc_aux_out_a_oe, !m[0]);
			cyc(6); chk({pin_a, pin_b, kbc_aux_out_a_oe}, 6);
		end
		$display("aux test done");
		conclude;
	end
	initial begin
		#100000;
		n_fail++;
		conclude;
	end
endmodule
bind fgr_fast_ctrl fgr_fast_ctrl_monitor u_fgr_fast_ctrl_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .pslverr, .kbc_gate_out, .kbc_aux_port_a, .kbc_aux_port_b, .cpu_addr_mask_n, .fast_gate_line,
	.fast_reset_pulse_n, .kbc_aux_out_a_o, .kbc_aux_out_a_oe, .kbc_aux_out_b_o, .kbc_aux_out_b_oe);
